/* File: design/trig_sel_pkg.sv */
package trig_sel_pkg;

  // ----------------------------------------
  // Selector field
  // ----------------------------------------
  localparam int SEL_W = 4;
  localparam int SEL_LSB = 4;
  localparam int SEL_MSB = 7;
  localparam logic [3:0] SEL_RESET = 4'h0;

  // Selector codes
  localparam logic [3:0] SEL_EXT_PIN = 4'h0;
  localparam logic [3:0] SEL_TIMER_A = 4'h1;
  localparam logic [3:0] SEL_CH0_MATCH = 4'h2;
  localparam logic [3:0] SEL_DELAY_A = 4'h3;
  localparam logic [3:0] SEL_DELAY_B = 4'h4;

  // Trigger source count
  localparam int SRC_N = 5;

  // Start-bit state machine
  typedef enum logic [1:0] {
    ST_IDLE = 2'b01,
    ST_ARMED = 2'b10
  } arm_state_t;

endpackage

/* File: design/trig_src_if.sv */
`timescale 1ns/1ps
`default_nettype none

// Bundle of trigger sources between the synchroniser and the selector
interface trig_src_if;
  logic [4:0] pulse;
  modport src (output pulse);
  modport dst (input pulse);
endinterface

`default_nettype wire

/* File: design/pin_edge_sync.sv */
`timescale 1ns/1ps
`default_nettype none

// Three-stage synchroniser with rising-edge pulse for the external pin
module pin_edge_sync (
  // Clock and reset
  input wire logic clk_i,
  input wire logic rst_b_i,
  input wire logic ce_i,
  // Asynchronous pin
  input wire logic pin_i,
  // Synchronised edge
  output logic rise_o
);

  logic s1_reg;
  logic s2_reg;
  logic s3_reg;
  logic level_reg;
  logic agree;

  // ----------------------------------------
  // Synchroniser chain
  // ----------------------------------------
  always_ff @(posedge clk_i) begin
    if (!rst_b_i) begin
      s1_reg <= 1'b0;
      s2_reg <= 1'b0;
      s3_reg <= 1'b0;
      level_reg <= 1'b0;
    end else if (ce_i) begin
      s1_reg <= pin_i;
      s2_reg <= s1_reg;
      s3_reg <= s2_reg;
      level_reg <= agree ? s3_reg : level_reg;
    end
  end

  // Stages two and three must agree before a level is believed
  assign agree = (s2_reg == s3_reg);
  // A rise counts once stages two and three agree on the new high level
  assign rise_o = ce_i & agree & s3_reg & ~level_reg;

endmodule // pin_edge_sync

`default_nettype wire

/* File: design/adc_group0_trigger_select.sv */
`timescale 1ns/1ps
`default_nettype none

module adc_group0_trigger_select (
  // Clock, reset, enable
  input wire logic clk_i,
  input wire logic rst_b_i,
  input wire logic ce_i,
  // Control byte from the converter control register
  input wire logic [7:0] ctrl_wdata_i,
  input wire logic ctrl_we_i,
  input wire logic conversion_start_bit_i,
  // Trigger sources
  input wire logic ext_conv_trigger_pin_i,
  input wire logic timer_a_reg_trigger_i,
  input wire logic timer_ch0_match_trigger_i,
  input wire logic delayed_start_request_a_i,
  input wire logic delayed_start_request_b_i,
  // Sequencer side
  output logic [3:0] group0_trigger_select_o,
  output logic group0_start_o,
  output logic select_invalid_o,
  output logic select_changed_armed_o
);

  logic [3:0] sel_reg;
  logic [3:0] sel_next;
  logic start_reg;
  logic invalid_reg;
  logic changed_reg;
  trig_sel_pkg::arm_state_t st_reg;
  trig_sel_pkg::arm_state_t st_next;
  logic [4:0] src_vec;
  // Sources padded to eight entries so every three-bit index is in bounds
  logic [7:0] src_pad;
  logic armed;
  logic take;
  logic sel_moves;
  logic sel_valid;
  logic hit;
  logic ext_rise;

  trig_src_if src_bus ();

  // ----------------------------------------
  // Pin synchroniser
  // ----------------------------------------
  pin_edge_sync u_pin (
    .clk_i(clk_i),
    .rst_b_i(rst_b_i),
    .ce_i(ce_i),
    .pin_i(ext_conv_trigger_pin_i),
    .rise_o(ext_rise)
  );

  // Gather sources in selector order
  assign src_bus.pulse = {delayed_start_request_b_i, delayed_start_request_a_i,
                          timer_ch0_match_trigger_i, timer_a_reg_trigger_i, ext_rise};
  assign src_vec = src_bus.pulse;

  // ----------------------------------------
  // Selector decode
  // ----------------------------------------
  // Codes 0 to 4 name a source; every code above is prohibited
  function automatic logic code_valid(input logic [3:0] code);
    code_valid = (code <= trig_sel_pkg::SEL_DELAY_B);
  endfunction

  // New selector value taken from the control byte on a write
  assign sel_next = ctrl_we_i ?
    ctrl_wdata_i[trig_sel_pkg::SEL_MSB:trig_sel_pkg::SEL_LSB] : sel_reg;
  // A write that alters the code
  assign sel_moves = ctrl_we_i & (sel_next != sel_reg);

  // ----------------------------------------
  // Trigger qualification
  // ----------------------------------------
  // Codes 5 to 7 land on the zero padding; codes 8 to 15 are masked by sel_valid
  assign src_pad = {3'h0, src_vec};
  assign sel_valid = code_valid(sel_reg);
  // Source mux; prohibited codes pick nothing
  assign hit = sel_valid & src_pad[sel_reg[2:0]];
  // Armed means the start bit was high at the previous edge
  assign armed = (st_reg == trig_sel_pkg::ST_ARMED);
  // Only an armed converter takes a trigger; armed stays set for one enabled cycle after the start bit clears
  assign take = hit & armed;

  // Arm state follows the start bit
  always_comb begin
    case (st_reg)
      trig_sel_pkg::ST_IDLE: st_next = conversion_start_bit_i ?
        trig_sel_pkg::ST_ARMED : trig_sel_pkg::ST_IDLE;
      trig_sel_pkg::ST_ARMED: st_next = conversion_start_bit_i ?
        trig_sel_pkg::ST_ARMED : trig_sel_pkg::ST_IDLE;
      default: st_next = trig_sel_pkg::ST_IDLE;
    endcase
  end

  // ----------------------------------------
  // Registers
  // ----------------------------------------
  // Selector field and its prohibited-code flag
  always_ff @(posedge clk_i) begin
    if (!rst_b_i) begin
      sel_reg <= trig_sel_pkg::SEL_RESET;
      invalid_reg <= 1'b0;
    end else if (ce_i) begin
      sel_reg <= sel_next;
      invalid_reg <= ~code_valid(sel_next);
    end
  end

  // Arm state follows the start bit one cycle late
  always_ff @(posedge clk_i) begin
    if (!rst_b_i) begin
      st_reg <= trig_sel_pkg::ST_IDLE;
    end else if (ce_i) begin
      st_reg <= st_next;
    end
  end

  // Start pulse and armed-change flag, each one enabled cycle long
  always_ff @(posedge clk_i) begin
    if (!rst_b_i) begin
      start_reg <= 1'b0;
      changed_reg <= 1'b0;
    end else if (ce_i) begin
      start_reg <= take;
      // A selector change made while armed is reported, not blocked
      changed_reg <= sel_moves & armed;
    end
  end

  // ----------------------------------------
  // Outputs
  // ----------------------------------------
  // Every output comes straight from a flip-flop
  assign group0_trigger_select_o = sel_reg;
  assign group0_start_o = start_reg;
  assign select_invalid_o = invalid_reg;
  assign select_changed_armed_o = changed_reg;

  // ----------------------------------------
  // Assertions
  // ----------------------------------------
  a_sel_reset_val: assert property (@(posedge clk_i)
    $rose(rst_b_i) |-> sel_reg == 4'h0) else $error("selector not reset");
  a_ext_start: assert property (@(posedge clk_i) disable iff (!rst_b_i)
    ce_i && sel_reg == 4'h0 && ext_rise && st_reg == trig_sel_pkg::ST_ARMED
    |=> group0_start_o) else $error("pin trigger missed");
  a_tim_a_start: assert property (@(posedge clk_i) disable iff (!rst_b_i)
    ce_i && sel_reg == 4'h1 && timer_a_reg_trigger_i && st_reg == trig_sel_pkg::ST_ARMED
    |=> group0_start_o) else $error("timer A trigger missed");
  a_ch0_start: assert property (@(posedge clk_i) disable iff (!rst_b_i)
    ce_i && sel_reg == 4'h2 && timer_ch0_match_trigger_i && st_reg == trig_sel_pkg::ST_ARMED
    |=> group0_start_o) else $error("ch0 trigger missed");
  a_dly_a_start: assert property (@(posedge clk_i) disable iff (!rst_b_i)
    ce_i && sel_reg == 4'h3 && delayed_start_request_a_i && st_reg == trig_sel_pkg::ST_ARMED
    |=> group0_start_o) else $error("delay A trigger missed");
  a_dly_b_start: assert property (@(posedge clk_i) disable iff (!rst_b_i)
    ce_i && sel_reg == 4'h4 && delayed_start_request_b_i && st_reg == trig_sel_pkg::ST_ARMED
    |=> group0_start_o) else $error("delay B trigger missed");
  a_bad_sel_quiet: assert property (@(posedge clk_i) disable iff (!rst_b_i)
    ce_i && sel_reg > 4'h4 |=> !group0_start_o) else $error("prohibited code started");
  a_idle_quiet: assert property (@(posedge clk_i) disable iff (!rst_b_i)
    ce_i && !conversion_start_bit_i [*2] |=> !group0_start_o) else $error("start while idle");
  a_change_flag: assert property (@(posedge clk_i) disable iff (!rst_b_i)
    ce_i && ctrl_we_i && sel_next != sel_reg && st_reg == trig_sel_pkg::ST_ARMED
    |=> select_changed_armed_o) else $error("armed change not flagged");
  a_change_quiet: assert property (@(posedge clk_i) disable iff (!rst_b_i)
    ce_i && !ctrl_we_i |=> !select_changed_armed_o)
    else $error("change flag without a write");

  // Selector field: a write lands whole, otherwise the code stands
  a_sel_write_lands: assert property (@(posedge clk_i) disable iff (!rst_b_i)
    ce_i && ctrl_we_i |=> group0_trigger_select_o ==
    $past(ctrl_wdata_i[trig_sel_pkg::SEL_MSB:trig_sel_pkg::SEL_LSB]))
    else $error("selector write lost");
  a_sel_holds: assert property (@(posedge clk_i) disable iff (!rst_b_i)
    ce_i && !ctrl_we_i |=> $stable(group0_trigger_select_o))
    else $error("selector moved without a write");

  // Prohibited-code flag tracks the selector held
  a_invalid_level: assert property (@(posedge clk_i) disable iff (!rst_b_i)
    ce_i |=> select_invalid_o == (group0_trigger_select_o > 4'h4))
    else $error("prohibited flag wrong");

  // Clock enable low freezes every output
  a_ce_freeze: assert property (@(posedge clk_i) disable iff (!rst_b_i)
    !ce_i |=> $stable(group0_trigger_select_o) && $stable(group0_start_o) &&
    $stable(select_invalid_o) && $stable(select_changed_armed_o))
    else $error("state moved while disabled");

  // Arm state stays one-hot and drops one cycle after the start bit
  a_state_onehot: assert property (@(posedge clk_i) disable iff (!rst_b_i)
    $onehot(st_reg)) else $error("arm state not one-hot");
  a_arm_drop: assert property (@(posedge clk_i) disable iff (!rst_b_i)
    ce_i && !conversion_start_bit_i |=> st_reg == trig_sel_pkg::ST_IDLE)
    else $error("arm state kept after start bit cleared");

  // One pin edge gives one qualified pulse
  a_pin_edge_once: assert property (@(posedge clk_i) disable iff (!rst_b_i)
    ce_i && ext_rise |=> !ext_rise) else $error("pin edge counted twice");

  // Main scenarios reached

  c_ext_start: cover property (@(posedge clk_i) sel_reg == 4'h0 && group0_start_o);
  c_dly_b_start: cover property (@(posedge clk_i) sel_reg == 4'h4 && group0_start_o);
  c_ch0_start: cover property (@(posedge clk_i) sel_reg == 4'h2 && group0_start_o);
  c_bad_sel: cover property (@(posedge clk_i) select_invalid_o);
  c_armed_change: cover property (@(posedge clk_i) select_changed_armed_o);

endmodule // adc_group0_trigger_select

`default_nettype wire

/* File: tb/trig_source_model.sv */
`timescale 1ns/1ps
`default_nettype none

// Timer unit and trigger pin stand-in, one source per request
module trig_source_model (
  // Clock
  input wire logic clk_i,
  // Request from the bench
  input wire logic [2:0] src_i,
  input wire logic go_i,
  // Trigger outputs
  output logic pin_o,
  output logic [4:1] pulse_o
);
  logic [2:0] hold_reg = 3'h0;

  // One source fires per request, so no two requests ever coincide
  always @(posedge clk_i) begin
    pulse_o <= 4'h0;
    if (hold_reg != 3'h0) hold_reg <= hold_reg - 3'h1;
    if (go_i && src_i == 3'h0) hold_reg <= 3'h5;
    if (go_i && src_i != 3'h0) pulse_o[src_i] <= 1'h1;
  end

  // Pin stays high a few cycles so the synchroniser sees the edge
  assign pin_o = (hold_reg != 3'h0);
endmodule // trig_source_model

`default_nettype wire

/* File: tb/adc_group0_trigger_select_bench.sv */
`timescale 1ns/1ps
`default_nettype none

module adc_group0_trigger_select_bench;
  logic clk_i = 0, rst_b_i = 0, ce_i = 1, we = 0, arm = 0, go = 0;
  logic [7:0] wdata = 8'h00;
  logic [2:0] src = 3'h0;
  logic [3:0] sel_o;
  logic [4:1] pulse;
  logic pin, st, inv, chg;
  int fails = 0, samples_checked = 0, n;

  // Clock at 200 MHz
  initial forever #2.5 clk_i = ~clk_i;

  trig_source_model trig_source_model_i (.clk_i(clk_i), .src_i(src), .go_i(go),
    .pin_o(pin), .pulse_o(pulse));
  adc_group0_trigger_select adc_group0_trigger_select_i (.clk_i(clk_i), .rst_b_i(rst_b_i),
    .ce_i(ce_i), .ctrl_wdata_i(wdata), .ctrl_we_i(we), .conversion_start_bit_i(arm),
    .ext_conv_trigger_pin_i(pin), .timer_a_reg_trigger_i(pulse[1]),
    .timer_ch0_match_trigger_i(pulse[2]), .delayed_start_request_a_i(pulse[3]),
    .delayed_start_request_b_i(pulse[4]), .group0_trigger_select_o(sel_o),
    .group0_start_o(st), .select_invalid_o(inv), .select_changed_armed_o(chg));

  // Compare tasks
  task automatic cmp4(input logic [3:0] got, input logic [3:0] exp);
    samples_checked++;
    if (got !== exp) begin
      fails++;
      $display("[ERR] %0t selector %h expected %h", $time, got, exp);
    end
  endtask
  task automatic cmpn(input int got, input int exp);
    samples_checked++;
    if (got != exp) begin
      fails++;
      $display("[ERR] %0t count %0d expected %0d", $time, got, exp);
    end
  endtask

  // Write the selector with the start bit cleared, then arm again
  task automatic write_sel(input logic [3:0] code);
    @(negedge clk_i) arm = 0;
    @(negedge clk_i) begin wdata = {code, 4'h0}; we = 1; end
    @(negedge clk_i) begin we = 0; arm = 1; end
    repeat (2) @(negedge clk_i);
  endtask

  // Fire one source and count start pulses
  task automatic fire(input logic [2:0] s);
    @(negedge clk_i) begin src = s; go = 1; end
    @(negedge clk_i) go = 0;
    n = 0;
    repeat (12) @(posedge clk_i) #1 if (st === 1'h1) n++;
  endtask

  task automatic test_codes;
    for (int c = 0; c < 5; c++) begin
      write_sel(c[3:0]);
      cmp4(sel_o, c[3:0]);
      cmp4({3'h0, inv}, 4'h0);
      for (int s = 0; s < 5; s++) begin
        fire(s[2:0]);
        cmpn(n, int'(s == c));
      end
    end
    $display("test_codes done");
  endtask

  task automatic test_prohibited;
    logic [3:0] bad [5] = '{4'h5, 4'h6, 4'h7, 4'h8, 4'hf};
    foreach (bad[i]) begin
      write_sel(bad[i]);
      cmp4({3'h0, inv}, 4'h1);
      for (int s = 0; s < 5; s++) begin
        fire(s[2:0]);
        cmpn(n, 0);
      end
    end
    $display("test_prohibited done");
  endtask

  // Start bit low or clock enable low: triggers are refused
  task automatic test_refused;
    write_sel(4'h1);
    @(negedge clk_i) arm = 0;
    repeat (2) @(negedge clk_i);
    fire(3'h1);
    cmpn(n, 0);
    @(negedge clk_i) arm = 1;
    repeat (2) @(negedge clk_i);
    ce_i = 0;
    fire(3'h1);
    cmpn(n, 0);
    @(negedge clk_i) ce_i = 1;
    fire(3'h1);
    cmpn(n, 1);
    $display("test_refused done");
  endtask

  // Selector rewritten while armed: the flag pulses for one cycle
  task automatic test_change;
    write_sel(4'h1);
    @(negedge clk_i) begin wdata = {4'h2, 4'h0}; we = 1; end
    @(negedge clk_i) we = 0;
    cmp4({3'h0, chg}, 4'h1);
    cmp4(sel_o, 4'h2);
    @(negedge clk_i);
    cmp4({3'h0, chg}, 4'h0);
    @(negedge clk_i) begin wdata = {4'h2, 4'h0}; we = 1; end
    @(negedge clk_i) we = 0;
    cmp4({3'h0, chg}, 4'h0);
    $display("test_change done");
  endtask

  // Reset in mid-run returns the selector and flags to idle
  task automatic test_reset;
    write_sel(4'h9);
    cmp4({3'h0, inv}, 4'h1);
    @(negedge clk_i) rst_b_i = 0;
    repeat (3) @(negedge clk_i);
    rst_b_i = 1;
    cmp4(sel_o, 4'h0);
    cmp4({3'h0, inv}, 4'h0);
    fire(3'h0);
    cmpn(n, 1);
    $display("test_reset done");
  endtask

  task automatic summarize;
    $display("checks %0d mismatches %0d", samples_checked, fails);
    if (fails == 0 && samples_checked > 0) $display("No errors found");
    else $display("Errors were found");
    $finish;
  endtask

  // Reset, then the tests
  initial begin
    repeat (3) @(negedge clk_i);
    rst_b_i = 1;
    cmp4(sel_o, 4'h0);
    test_codes();
    test_prohibited();
    test_refused();
    test_change();
    test_reset();
    summarize();
  end

  // Watchdog
  initial begin
    #20000;
    fails++;
    summarize();
  end
endmodule // adc_group0_trigger_select_bench

`default_nettype wire
